/* File: sps_pkg.sv */
// How it works
// RQ1: software erases a page before writing it
// RQ2: buffer filled word by word, any time; loads are taken only while no erase or write runs
// RQ3: buffer words may load in any order
// RQ4: erase pattern plus instruction within four clocks
// RQ5: halting-section erase halts core, other stays readable
// RQ6: load pattern stores data pair at word index
// RQ7: buffer cleared on write done, re-enable, reset
// RQ8: software loads each buffer word only once
// RQ9: eeprom write mid-load discards loaded words
// RQ10: write pattern plus instruction within four clocks
// RQ11: halting-section write halts core until done
// RQ12: ready interrupt held while enable bit clear
// RQ13: section busy blocks reads, busy flag set
// RQ14: software keeps vectors out of blocked section
// RQ15: software re-enables section before reading it
// RQ16: software uses same page for erase, write
// RQ17: enable bit stays set during erase or write
// RQ18: undefined command patterns have no effect
// RQ19: enable clears on instruction or four clocks
// RQ20: buffer load start clears busy flag
// RQ21: target page latched when operation starts
package sps_pkg;
	// register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00; // program_store_control_reg
	localparam logic [4:0] OFS_ZPTR = 5'h04; // address pointer
	localparam logic [4:0] OFS_DATA = 5'h08; // data_register_pair
	localparam logic [4:0] OFS_SPM  = 5'h0c; // store_program_instruction trigger
	localparam logic [4:0] OFS_STAT = 5'h10; // sequencer status
	// control register fields
	localparam int BIT_RIE  = 7; // ready_interrupt_enable
	localparam int BIT_BUSY = 6; // section_busy_flag
	localparam int BIT_RRE  = 4; // section_read_enable
	localparam int BIT_PGW  = 2; // page_write_cmd
	localparam int BIT_PGE  = 1; // page_erase_cmd
	localparam int BIT_SPE  = 0; // self_program_enable
	localparam logic [7:0] CTRL_RST = 8'h00;
	// accepted lower-five-bit patterns
	localparam logic [4:0] PAT_LOAD  = 5'h01;
	localparam logic [4:0] PAT_ERASE = 5'h03;
	localparam logic [4:0] PAT_WRITE = 5'h05;
	localparam logic [4:0] PAT_RRE   = 5'h11;
	// timing
	localparam logic [2:0] WIN_CLKS   = 3'h4;    // instruction window
	localparam int         CLK_NS     = 20;      // clock period
	localparam int         OP_TIME_US = 4000;    // erase or write time
	localparam int         OP_CYCLES_DEF = OP_TIME_US * 1000 / CLK_NS;
	localparam int         OP_W       = 18;      // op counter width
	// pointer layout
	localparam int         WORD_LSB  = 1;
	localparam int         WORD_W    = 5;
	localparam int         PAGE_LSB  = 6;
	localparam int         PAGE_W    = 7;
	localparam int         PAGE_WORDS = 32;
	localparam logic [6:0] RWW_PAGES = 7'h60;  // pages below are readable section
	// armed command
	typedef enum logic [2:0] {CMD_NONE, CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_RRE} sps_cmd_t;
	// operation state
	typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} sps_state_t;
	// port to the flash array
	typedef struct packed {
		logic        erase; // one-cycle erase start
		logic        prog;  // one buffer word to program
		logic [6:0]  page;  // latched target page
		logic [4:0]  word;  // word within page
		logic [15:0] data;  // word value
	} sps_flash_t;
endpackage

/* File: sps_page_buf.sv */
`timescale 1ns/1ps
// temporary page buffer storage, registered read
module sps_page_buf (
	input  wire logic        clk_i,
	input  wire logic        we_i,
	input  wire logic [4:0]  waddr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic [4:0]  raddr_i,
	output logic      [15:0] rdata_o
);
	logic [15:0] mem_q [32]; // word storage, validity kept outside
	logic [15:0] rd_d;       // next read data

	// read mux
	always_comb begin
		rd_d = mem_q[raddr_i];
	end

	// write and read registers
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
		rdata_o <= rd_d;
	end
endmodule // sps_page_buf

/* File: sps_countdown.sv */
`timescale 1ns/1ps
// loadable down counter with active and last-cycle flags
module sps_countdown #(
	parameter int W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] val_i,
	input  wire logic         clr_i,
	output logic              active_o,
	output logic              last_o
);
	logic [W-1:0] cnt_q; // remaining cycles
	logic [W-1:0] cnt_d;

	// next count: clear beats load beats decrement
	always_comb begin
		cnt_d = cnt_q;
		if (clr_i) begin
			cnt_d = '0;
		end else if (load_i) begin
			cnt_d = val_i;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - W'(1);
		end
	end

	// count register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign active_o = (cnt_q != '0);
	assign last_o   = (cnt_q == W'(1));
endmodule // sps_countdown

/* File: sps_flash_seq.sv */
`timescale 1ns/1ps
// self-programming sequencer with ahb-lite register access
module sps_flash_seq #(
	parameter int OP_CYCLES = sps_pkg::OP_CYCLES_DEF
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         hsel_i,
	input  wire logic [31:0]  haddr_i,
	input  wire logic [1:0]   htrans_i,
	input  wire logic         hwrite_i,
	input  wire logic [2:0]   hsize_i,
	input  wire logic [31:0]  hwdata_i,
	input  wire logic         hready_i,
	input  wire logic         eeprom_wr_i,
	output logic      [31:0]  hrdata_o,
	output logic              hreadyout_o,
	output logic              hresp_o,
	output logic              irq_o,
	output logic              cpu_halt_o,
	output logic              rww_blocked_o,
	output sps_pkg::sps_flash_t flash_o
);
	////////////////////////////////////////////////////////////////////////
	// bus front end
	////////////////////////////////////////////////////////////////////////
	logic        wp_q, wp_d;   // write data phase pending
	logic [4:0]  wa_q, wa_d;   // latched write offset
	logic [31:0] rd_q, rd_d;   // read data
	logic        addr_ok;      // address phase taken
	logic [31:0] rmux;         // read value at address phase

	// decoded hit on one register
	function automatic logic hit(input logic [31:0] a, input logic [4:0] o);
		return (a[31:5] == 27'h0) && (a[4:0] == o);
	endfunction

	assign addr_ok = hsel_i && hready_i && htrans_i[1];

	////////////////////////////////////////////////////////////////////////
	// control state
	////////////////////////////////////////////////////////////////////////
	logic               rie_q, rie_d;     // ready_interrupt_enable
	logic               spe_q, spe_d;     // self_program_enable
	logic               busy_q, busy_d;   // section_busy_flag
	sps_pkg::sps_cmd_t  cmd_q, cmd_d;     // armed command
	sps_pkg::sps_state_t st_q, st_d;      // operation state
	logic [15:0]        zptr_q, zptr_d;   // address pointer
	logic [15:0]        dreg_q, dreg_d;   // data_register_pair
	logic [6:0]         page_q, page_d;   // latched page
	logic               rww_q, rww_d;     // target in readable section
	logic [31:0]        valid_q, valid_d; // loaded buffer words
	logic [5:0]         strm_q, strm_d;   // write stream index
	logic               beat_q, beat_d;   // programming beat
	logic [4:0]         bword_q, bword_d; // beat word index
	logic               er_q, er_d;       // erase pulse

	logic        ctrl_wr, spm_wr;  // register write strobes
	logic [4:0]  pat;              // written command pattern
	logic        pat_ok;           // pattern is one we accept
	logic        arm;              // command armed this cycle
	logic        armed;            // instruction window open
	logic        spm_take;         // instruction accepted
	logic        load_take;        // buffer load accepted
	logic        start;            // erase or write begins
	logic        op_done;          // operation finished
	logic        win_act, win_last;
	logic        op_act;
	logic [6:0]  zpage;
	logic [4:0]  zword;
	logic        buf_we;
	logic [15:0] buf_rdata;

	assign ctrl_wr = wp_q && (wa_q == sps_pkg::OFS_CTRL);
	assign spm_wr  = wp_q && (wa_q == sps_pkg::OFS_SPM);
	assign pat     = hwdata_i[4:0];
	// only the four supported patterns arm anything
	assign pat_ok  = (pat == sps_pkg::PAT_LOAD) || (pat == sps_pkg::PAT_ERASE) ||
	                 (pat == sps_pkg::PAT_WRITE) || (pat == sps_pkg::PAT_RRE); // RQ18
	assign arm     = ctrl_wr && pat_ok && (st_q == sps_pkg::ST_IDLE);
	assign armed   = spe_q && win_act && (st_q == sps_pkg::ST_IDLE); // RQ19
	assign spm_take  = spm_wr && armed;
	assign load_take = spm_take && (cmd_q == sps_pkg::CMD_LOAD);
	assign start     = spm_take && ((cmd_q == sps_pkg::CMD_ERASE) || (cmd_q == sps_pkg::CMD_WRITE));
	assign op_done   = (st_q != sps_pkg::ST_IDLE) && !op_act;
	// erase and write use only the page field
	assign zpage = zptr_q[sps_pkg::PAGE_LSB +: sps_pkg::PAGE_W]; // RQ4 RQ10
	assign zword = zptr_q[sps_pkg::WORD_LSB +: sps_pkg::WORD_W]; // RQ6
	// any word may load in any order, first load wins
	assign buf_we = load_take && !valid_q[zword]; // RQ3

	// four-clock window after arming
	sps_countdown #(.W(3)) u_win (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.load_i   (arm),
		.val_i    (sps_pkg::WIN_CLKS),
		.clr_i    (spm_take),
		.active_o (win_act),
		.last_o   (win_last)
	);

	// erase or write duration
	sps_countdown #(.W(sps_pkg::OP_W)) u_op (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.load_i   (start),
		.val_i    (sps_pkg::OP_W'(OP_CYCLES)),
		.clr_i    (1'b0),
		.active_o (op_act),
		.last_o   ()
	);

	// temporary page buffer
	sps_page_buf u_buf (
		.clk_i   (clk_i),
		.we_i    (buf_we), // RQ2 RQ6
		.waddr_i (zword),
		.wdata_i (dreg_q),
		.raddr_i (strm_q[4:0]),
		.rdata_o (buf_rdata)
	);

	// read value mux
	always_comb begin
		rmux = 32'h0;
		if (hit(haddr_i, sps_pkg::OFS_CTRL)) begin
			rmux[sps_pkg::BIT_RIE]  = rie_q;
			rmux[sps_pkg::BIT_BUSY] = busy_q;
			rmux[sps_pkg::BIT_RRE]  = (cmd_q == sps_pkg::CMD_RRE);
			rmux[sps_pkg::BIT_PGW]  = (cmd_q == sps_pkg::CMD_WRITE);
			rmux[sps_pkg::BIT_PGE]  = (cmd_q == sps_pkg::CMD_ERASE);
			rmux[sps_pkg::BIT_SPE]  = spe_q;
		end else if (hit(haddr_i, sps_pkg::OFS_ZPTR)) begin
			rmux = {16'h0, zptr_q};
		end else if (hit(haddr_i, sps_pkg::OFS_DATA)) begin
			rmux = {16'h0, dreg_q};
		end else if (hit(haddr_i, sps_pkg::OFS_STAT)) begin
			rmux = {29'h0, rww_blocked_o, cpu_halt_o, op_act};
		end
	end

	// bus next state
	always_comb begin
		wp_d = 1'b0;
		wa_d = wa_q;
		rd_d = rd_q;
		if (addr_ok && hwrite_i && (haddr_i[31:5] == 27'h0)) begin
			wp_d = 1'b1;
			wa_d = haddr_i[4:0];
		end
		if (addr_ok && !hwrite_i) begin
			rd_d = rmux;
		end
	end

	// bus registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wp_q <= 1'b0;
			wa_q <= 5'h00;
			rd_q <= 32'h0;
		end else begin
			wp_q <= wp_d;
			wa_q <= wa_d;
			rd_q <= rd_d;
		end
	end

	// sequencer next state
	always_comb begin
		rie_d   = rie_q;
		spe_d   = spe_q;
		busy_d  = busy_q;
		cmd_d   = cmd_q;
		st_d    = st_q;
		zptr_d  = zptr_q;
		dreg_d  = dreg_q;
		page_d  = page_q;
		rww_d   = rww_q;
		valid_d = valid_q;
		strm_d  = strm_q;
		er_d    = 1'b0;
		// pointer and data pair writes
		if (wp_q && (wa_q == sps_pkg::OFS_ZPTR)) begin
			zptr_d = hwdata_i[15:0];
		end
		if (wp_q && (wa_q == sps_pkg::OFS_DATA)) begin
			dreg_d = hwdata_i[15:0];
		end
		// window ran out with no instruction
		if (spe_q && (st_q == sps_pkg::ST_IDLE) && win_last && !spm_wr) begin
			spe_d = 1'b0; // RQ19
			cmd_d = sps_pkg::CMD_NONE;
		end
		// control write: interrupt enable always, command when idle
		if (ctrl_wr) begin
			rie_d = hwdata_i[sps_pkg::BIT_RIE];
		end
		if (arm) begin
			spe_d = 1'b1;
			case (pat)
				sps_pkg::PAT_ERASE: cmd_d = sps_pkg::CMD_ERASE;
				sps_pkg::PAT_WRITE: cmd_d = sps_pkg::CMD_WRITE;
				sps_pkg::PAT_RRE: begin
					cmd_d   = sps_pkg::CMD_RRE;
					valid_d = 32'h0; // RQ7
				end
				default: cmd_d = sps_pkg::CMD_LOAD;
			endcase
		end
		// eeprom write during loading loses everything; a load in the same cycle still lands
		if (eeprom_wr_i) begin
			valid_d = 32'h0; // RQ9
		end
		// accepted instruction
		if (spm_take) begin
			case (cmd_q)
				sps_pkg::CMD_LOAD: begin
					valid_d[zword] = 1'b1;
					busy_d = 1'b0; // RQ20
					spe_d  = 1'b0; // RQ19
					cmd_d  = sps_pkg::CMD_NONE;
				end
				sps_pkg::CMD_ERASE, sps_pkg::CMD_WRITE: begin
					st_d   = (cmd_q == sps_pkg::CMD_ERASE) ? sps_pkg::ST_ERASE : sps_pkg::ST_WRITE;
					page_d = zpage; // RQ21
					rww_d  = (zpage < sps_pkg::RWW_PAGES);
					busy_d = busy_q || (zpage < sps_pkg::RWW_PAGES); // RQ13
					er_d   = (cmd_q == sps_pkg::CMD_ERASE);
					strm_d = 6'h00;
				end
				default: begin
					busy_d = 1'b0;
					spe_d  = 1'b0; // RQ19
					cmd_d  = sps_pkg::CMD_NONE;
				end
			endcase
		end
		// write streams the buffer out one word a cycle
		if ((st_q == sps_pkg::ST_WRITE) && !strm_q[5]) begin
			strm_d = strm_q + 6'h01;
		end
		// enable holds until completion
		if (op_done) begin
			st_d  = sps_pkg::ST_IDLE;
			spe_d = 1'b0; // RQ17
			cmd_d = sps_pkg::CMD_NONE;
			if (st_q == sps_pkg::ST_WRITE) begin
				valid_d = 32'h0; // RQ7
			end
		end
		beat_d  = (st_q == sps_pkg::ST_WRITE) && !strm_q[5] && valid_q[strm_q[4:0]];
		bword_d = strm_q[4:0];
	end

	// sequencer registers, reset empties the buffer
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rie_q   <= sps_pkg::CTRL_RST[sps_pkg::BIT_RIE];
			spe_q   <= sps_pkg::CTRL_RST[sps_pkg::BIT_SPE];
			busy_q  <= sps_pkg::CTRL_RST[sps_pkg::BIT_BUSY];
			cmd_q   <= sps_pkg::CMD_NONE;
			st_q    <= sps_pkg::ST_IDLE;
			zptr_q  <= 16'h0000;
			dreg_q  <= 16'h0000;
			page_q  <= 7'h00;
			rww_q   <= 1'b0;
			valid_q <= 32'h0; // RQ7
			strm_q  <= 6'h20;
			beat_q  <= 1'b0;
			bword_q <= 5'h00;
			er_q    <= 1'b0;
		end else begin
			rie_q   <= rie_d;
			spe_q   <= spe_d;
			busy_q  <= busy_d;
			cmd_q   <= cmd_d;
			st_q    <= st_d;
			zptr_q  <= zptr_d;
			dreg_q  <= dreg_d;
			page_q  <= page_d;
			rww_q   <= rww_d;
			valid_q <= valid_d;
			strm_q  <= strm_d;
			beat_q  <= beat_d;
			bword_q <= bword_d;
			er_q    <= er_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	////////////////////////////////////////////////////////////////////////
	assign hrdata_o      = rd_q;
	assign hreadyout_o   = 1'b1;
	assign hresp_o       = 1'b0;
	assign irq_o         = rie_q && !spe_q; // RQ12
	assign cpu_halt_o    = (st_q != sps_pkg::ST_IDLE) && !rww_q; // RQ5 RQ11
	assign rww_blocked_o = busy_q; // RQ13
	assign flash_o = '{erase: er_q, prog: beat_q, page: page_q, word: bword_q, data: buf_rdata};

	////////////////////////////////////////////////////////////////////////
	// assertions
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_irq_level: assert property (rie_q && op_done && !ctrl_wr |=> irq_o) // RQ12
		else $error("irq missing after completion");
	a_spe_hold: assert property (st_q != sps_pkg::ST_IDLE |-> spe_q) // RQ17
		else $error("enable fell early");
	a_win_close: assert property (arm |-> ##[1:5] (!spe_q || st_q != sps_pkg::ST_IDLE)) // RQ19
		else $error("window stuck");
	a_busy_set: assert property (start && zpage < sps_pkg::RWW_PAGES |=> rww_blocked_o && !cpu_halt_o) // RQ13
		else $error("no block");
	a_halt_core: assert property (start && zpage >= sps_pkg::RWW_PAGES |=> cpu_halt_o [*8]) // RQ5
		else $error("no halt");
	a_buf_clear: assert property (op_done && st_q == sps_pkg::ST_WRITE |=> valid_q == 32'h0) // RQ7
		else $error("buffer kept");
	a_eep_clear: assert property (eeprom_wr_i && !load_take |=> valid_q == 32'h0) // RQ9
		else $error("load survived");
	a_load_busy: assert property (load_take |=> !busy_q && !spe_q) // RQ20
		else $error("busy kept");
	a_bad_pattern: assert property (ctrl_wr && !pat_ok |=> $stable(spe_q) && $stable(cmd_q)) // RQ18
		else $error("bad pattern acted");
	a_page_latch: assert property ( // RQ21
		st_q != sps_pkg::ST_IDLE && $past(st_q) != sps_pkg::ST_IDLE |-> $stable(page_q))
		else $error("page moved");

	c_load: cover property (load_take);
	c_erase_rww: cover property (start && cmd_q == sps_pkg::CMD_ERASE && zpage < sps_pkg::RWW_PAGES);
	c_write_done: cover property (op_done && st_q == sps_pkg::ST_WRITE);
endmodule // sps_flash_seq

/* File: sps_flash_model.sv */
`timescale 1ns/1ps
// behavioural flash array standing behind the sequencer's flash port
module sps_flash_model (
	input  wire logic                clk_i,
	input  wire sps_pkg::sps_flash_t flash_i
);
	logic [15:0] mem [128][32]; // array contents, page by word
	int          beats = 0;     // count of programmed words seen

	////////////////////////////////////////////////////////////////
	// erase fills a page with ones; programming can only clear bits,
	// so a page that was never erased keeps unknown or stale data
	always @(posedge clk_i) begin
		if (flash_i.erase) begin
			for (int w = 0; w < 32; w++) begin
				mem[flash_i.page][w] <= 16'hffff;
			end
		end
		if (flash_i.prog) begin
			mem[flash_i.page][flash_i.word] <= mem[flash_i.page][flash_i.word] & flash_i.data;
			beats <= beats + 1;
		end
	end
endmodule // sps_flash_model

/* File: sps_flash_seq_bench.sv */
`timescale 1ns/1ps
// self-checking bench for the self-programming sequencer
module sps_flash_seq_bench;
	localparam int OPC = 64;  // shortened erase and write time
	logic                clk_i     = 1'b0;
	logic                rst_i     = 1'b1;
	logic                hsel      = 1'b0;
	logic [31:0]         haddr     = '0;
	logic [1:0]          htrans    = 2'h0;
	logic                hwrite    = 1'b0;
	logic [31:0]         hwdata    = '0;
	logic                eeprom_wr = 1'b0;
	logic [31:0]         hrdata;
	logic                hready;
	logic                irq;
	logic                halt;
	logic                blocked;
	sps_pkg::sps_flash_t flash;
	int                  miscompares  = 0;
	int                  total_checks = 0;
	logic [31:0]         rdv;            // last read data
	logic [15:0]         exp_mem [32];   // expected page contents
	logic [6:0]          pg;             // page under test
	logic [4:0]          bad [6] = '{5'h09, 5'h07, 5'h0f, 5'h13, 5'h1d, 5'h00};

	////////////////////////////////////////////////////////////////
	// clock and design under test
	always #10 clk_i = ~clk_i;

	sps_flash_seq #(.OP_CYCLES(OPC)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.eeprom_wr_i(eeprom_wr), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
		.irq_o(irq), .cpu_halt_o(halt), .rww_blocked_o(blocked), .flash_o(flash)
	);

	sps_flash_model u_fl (.clk_i(clk_i), .flash_i(flash));

	////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// verdict and end of run
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// one single ahb-lite transfer; entered just after a rising edge
	task automatic xfer(logic wr, logic [4:0] a, logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {27'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_i); while (hready !== 1'b1);
		rdv = hrdata;
	endtask

	// pointer value from page and word
	function automatic logic [15:0] zp(logic [6:0] p, logic [4:0] w);
		return {3'h0, p, w, 1'b0};
	endfunction

	// arm a command with ready interrupt enabled, then trigger
	task automatic cmd(logic [4:0] pat, logic [15:0] z);
		xfer(1'b1, sps_pkg::OFS_ZPTR, {16'h0, z});
		xfer(1'b1, sps_pkg::OFS_CTRL, {24'h0, 3'h4, pat});
		xfer(1'b1, sps_pkg::OFS_SPM, 32'h0);
	endtask

	// load one buffer word; each word once per buffer fill
	task automatic load(logic [6:0] p, logic [4:0] w, logic [15:0] d);
		xfer(1'b1, sps_pkg::OFS_DATA, {16'h0, d});
		cmd(sps_pkg::PAT_LOAD, zp(p, w));
	endtask

	// erase or write a page and watch status while it runs
	task automatic op(logic [4:0] pat, logic [6:0] p);
		logic h;
		int   n;
		h = (p >= sps_pkg::RWW_PAGES);
		n = 0;
		cmd(pat, zp(p, 5'h0));
		xfer(1'b1, sps_pkg::OFS_ZPTR, {16'h0, zp(~p, 5'h3)});
		xfer(1'b0, sps_pkg::OFS_CTRL, 32'h0);
		chk("enable held", rdv[0], 1);
		chk("cpu halt", halt, h);
		chk("blocked", blocked, !h);
		chk("irq in op", irq, 0);
		xfer(1'b0, sps_pkg::OFS_STAT, 32'h0);
		chk("status in op", rdv[2:0], {!h, h, 1'b1});
		do begin
			xfer(1'b0, sps_pkg::OFS_CTRL, 32'h0);
			n++;
		end while (rdv[0] !== 1'b0 && n < 100);
		chk("enable done", rdv[0], 0);
		chk("irq idle", irq, 1);
	endtask

	////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		finish_test;
	end

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		int          w;
		logic [15:0] d;
		void'($urandom(32'h5a01));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		xfer(1'b0, sps_pkg::OFS_CTRL, 32'h0);
		chk("ctrl reset", rdv, 0);
		chk("irq reset", irq, 0);
		// random words in random order into a readable-section page
		pg = 7'($urandom % 96);
		for (int i = 0; i < 32; i++) begin
			exp_mem[i] = 16'hffff;
		end
		repeat (10) begin
			w = $urandom % 32;
			d = 16'($urandom) & 16'h7fff;
			if (exp_mem[w] === 16'hffff) begin
				exp_mem[w] = d;
				load(pg, 5'(w), d);
			end
		end
		xfer(1'b0, sps_pkg::OFS_CTRL, 32'h0);
		chk("enable after load", rdv[0], 0);
		op(sps_pkg::PAT_ERASE, pg);
		op(sps_pkg::PAT_WRITE, pg);
		for (int i = 0; i < 32; i++) begin
			chk("flash word", u_fl.mem[pg][i], exp_mem[i]);
		end
		// a load clears the busy flag, buffer was emptied by the write
		chk("busy before load", blocked, 1);
		load(pg, 5'd7, 16'h1234);
		@(posedge clk_i);
		chk("busy after load", blocked, 0);
		w = u_fl.beats;
		op(sps_pkg::PAT_WRITE, pg);
		chk("beats after write", u_fl.beats - w, 1);
		// halting-section page
		pg = 7'(96 + $urandom % 32);
		load(pg, 5'd31, 16'h0a5c);
		op(sps_pkg::PAT_ERASE, pg);
		load(pg, 5'd0, 16'h5ac3);
		op(sps_pkg::PAT_WRITE, pg);
		chk("halt word 31", u_fl.mem[pg][31], 16'h0a5c);
		chk("halt word 0", u_fl.mem[pg][0], 16'h5ac3);
		// eeprom write in mid-load discards the buffer
		load(pg, 5'd2, 16'h0001);
		eeprom_wr <= 1'b1;
		@(posedge clk_i);
		eeprom_wr <= 1'b0;
		w = u_fl.beats;
		op(sps_pkg::PAT_WRITE, pg);
		chk("beats after eeprom", u_fl.beats - w, 0);
		// read-enable clears the buffer
		load(pg, 5'd3, 16'h0002);
		cmd(sps_pkg::PAT_RRE, 16'h0);
		w = u_fl.beats;
		op(sps_pkg::PAT_WRITE, pg);
		chk("beats after reenable", u_fl.beats - w, 0);
		// a reset in mid-run empties the buffer
		load(pg, 5'd4, 16'h0003);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		w = u_fl.beats;
		op(sps_pkg::PAT_WRITE, pg);
		chk("beats after reset", u_fl.beats - w, 0);
		// undefined patterns arm nothing
		foreach (bad[i]) begin
			xfer(1'b1, sps_pkg::OFS_CTRL, {27'h0, bad[i]});
			xfer(1'b0, sps_pkg::OFS_CTRL, 32'h0);
			chk("ignored pattern", rdv[4:0], 0);
		end
		// window runs out without a trigger
		xfer(1'b1, sps_pkg::OFS_CTRL, {27'h0, sps_pkg::PAT_LOAD});
		repeat (5) @(posedge clk_i);
		xfer(1'b0, sps_pkg::OFS_CTRL, 32'h0);
		chk("enable expired", rdv[0], 0);
		finish_test;
	end
endmodule // sps_flash_seq_bench
